// ==== core_model.sv ====
`timescale 1ns/1ps
module core_model (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Bench command and halt status
   input wire go,
   input wire core_hold,
   output reg sleep_instr
);
   // A halted core fetches nothing, so it cannot issue a sleep
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sleep_instr <= 1'b0;
      else
         sleep_instr <= go && !core_hold;
   end
endmodule

// ==== sleep_ctrl_regs.vh ====
`ifndef SLEEP_CTRL_REGS_VH
`define SLEEP_CTRL_REGS_VH
// Register map (byte addresses)
`define SLEEP_CONTROL_REG_OFF 12'h000
`define SLEEP_STATUS_REG_OFF 12'h004
`define SLEEP_CONFIG_REG_OFF 12'h008
// Control register fields
`define ARM_BIT 0
`define MODE_LSB 1
`define MODE_MSB 3
`define CTRL_RESET 8'h00
// Status register fields
`define ST_STATE_LSB 0
`define ST_MODE_LSB 4
`define ST_RESET_WAKE_BIT 8
// Config register fields
`define CFG_XTAL_BIT 0
`define CFG_STARTUP_LSB 16
`define CFG_RESET 32'h0040_0000
// Modes
`define MODE_IDLE 3'h0
`define MODE_ADC_QUIET 3'h1
`define MODE_POWER_DOWN 3'h2
`define MODE_POWER_SAVE 3'h3
`define MODE_STANDBY 3'h6
`define MODE_EXT_STANDBY 3'h7
// Timing
`define INT_WAKE_HOLD_CYCLES 4
`define STANDBY_WAKE_CYCLES 6
`endif

// ==== sleep_ctrl_sva.sv ====
`timescale 1ns/1ps
module sleep_ctrl_checker (
   // Clock, reset and bus
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire pready,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   // Core and wake sources
   input wire sleep_instr,
   input wire sys_reset_req,
   input wire core_hold,
   input wire resume_at_reset_vector,
   input wire wdt_irq,
   input wire adc_enabled,
   input wire adc_auto_start,
   // Clock gates
   input wire core_clock_en,
   input wire io_clock_en,
   input wire converter_clock_en,
   input wire usb_clock_en,
   input wire osc_en
);
   reg arm_r;
   reg rwake_r;
   reg [2:0] mode_r;
   wire asleep = !core_clock_en;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_r <= 1'b0;
         mode_r <= 3'h0;
         rwake_r <= 1'b0;
      end else begin
         if (psel && penable && pready && pwrite && paddr == 12'h000) begin
            arm_r <= pwdata[0];
            mode_r <= pwdata[3:1];
         end
         rwake_r <= core_hold && (rwake_r || sys_reset_req);
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence entered;
      ##[1:2] core_hold;
   endsequence
   sequence held_five;
      core_hold [*5];
   endsequence
   // Standby checks assume the bench selected a crystal beforehand
   no_arm_sleep_a: assert property (sleep_instr && !arm_r && !core_hold |=> !core_hold [*2])
      else $error("sleep without arm");
   sleep_entry_a: assert property (sleep_instr && arm_r && !core_hold |-> entered)
      else $error("armed sleep ignored");
   idle_clocks_a: assert property (asleep && mode_r == 3'h0 |-> io_clock_en && osc_en)
      else $error("idle gated too much");
   quiet_clocks_a: assert property (asleep && mode_r == 3'h1 |-> !io_clock_en
      && converter_clock_en && usb_clock_en && osc_en) else $error("quiet gates wrong");
   pd_clocks_a: assert property (asleep && mode_r[2:1] == 2'b01 |-> !osc_en
      && !io_clock_en && !converter_clock_en) else $error("power-down gates wrong");
   stby_clocks_a: assert property (asleep && mode_r[2:1] == 2'b11 |-> osc_en
      && !io_clock_en && !converter_clock_en) else $error("standby gates wrong");
   irq_hold_a: assert property ($rose(core_clock_en) && !rwake_r && !sys_reset_req |-> held_five)
      else $error("interrupt hold short");
   rst_resume_a: assert property (sys_reset_req && asleep |-> ##[1:80] resume_at_reset_vector)
      else $error("no reset resume");
   stby_wake_a: assert property (asleep && mode_r[2:1] == 2'b11 && $rose(wdt_irq)
      |-> ##[1:8] !core_hold) else $error("standby wake slow");
   adc_start_a: assert property ($rose(core_hold) && mode_r < 3'h2 && adc_enabled
      |-> ##[0:2] adc_auto_start) else $error("no conversion start");
endmodule
bind sleep_mode_controller sleep_ctrl_checker i_sleep_ctrl_checker (.pclk, .presetn, .psel,
   .penable, .pwrite, .pready, .paddr, .pwdata, .sleep_instr, .sys_reset_req, .core_hold,
   .resume_at_reset_vector, .wdt_irq, .adc_enabled, .adc_auto_start, .core_clock_en,
   .io_clock_en, .converter_clock_en, .usb_clock_en, .osc_en);

// ==== sleep_mode_controller.v ====
`timescale 1ns/1ps
`include "sleep_ctrl_regs.vh"
module sleep_mode_controller #(
   parameter STARTUP_CYCLES = 16'd64
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Processor core
   input wire sleep_instr,
   input wire sys_reset_req,
   output reg core_hold,
   output reg resume_at_reset_vector,
   output reg wake_irq_pending,
   // Wake sources
   input wire ext_irq_line_six,
   input wire ext_irq_six_is_level,
   input wire ext_irq_low_group,
   input wire pin_change_irq,
   input wire twi_addr_match_irq,
   input wire mem_ready_irq,
   input wire adc_done_irq,
   input wire wdt_irq,
   input wire other_io_irq,
   input wire usb_sync_irq,
   input wire bus_voltage_transition_irq,
   input wire usb_resume_irq,
   // ADC control
   input wire adc_enabled,
   output reg adc_auto_start,
   // Clock gate enables
   output reg core_clock_en,
   output reg flash_clock_en,
   output reg io_clock_en,
   output reg converter_clock_en,
   output reg usb_clock_en,
   output reg osc_en
);

   localparam ST_RUN = 3'h0;
   localparam ST_SLEEP = 3'h1;
   localparam ST_STARTUP = 3'h2;
   localparam ST_HOLD = 3'h3;
   localparam [7:0] CTRL_RST = `CTRL_RESET;

   reg [2:0] sleep_mode_select_r;
   reg sleep_arm_r;
   reg xtal_clock_r;
   reg [15:0] startup_r;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [2:0] cur_mode_r;
   reg [15:0] cnt_r;
   reg [15:0] cnt_nxt;
   reg reset_wake_r;
   reg irq_wake_r;
   reg wake;
   reg [2:0] mode_nxt;

   wire acc = psel && penable;
   wire wr = acc && pwrite;

   // Standby needs a crystal clock; otherwise it is treated as power-down
   function [2:0] eff_mode;
      input [2:0] m;
      input xtal;
      begin
         if ((m == `MODE_STANDBY || m == `MODE_EXT_STANDBY) && !xtal) begin
            eff_mode = `MODE_POWER_DOWN;
         end else if (m == `MODE_EXT_STANDBY) begin
            eff_mode = `MODE_STANDBY;
         end else if (m == `MODE_POWER_SAVE) begin
            eff_mode = `MODE_POWER_DOWN;
         end else begin
            eff_mode = m;
         end
      end
   endfunction

   // Interrupt wake qualified by mode; line six by level outside idle
   always @* begin
      // Gates must follow the new mode on the entry edge, not the stale one
      mode_nxt = cur_mode_r;
      if (state_r == ST_RUN && sleep_instr && sleep_arm_r) begin
         mode_nxt = eff_mode(sleep_mode_select_r, xtal_clock_r);
      end
      case (cur_mode_r)
         `MODE_IDLE: begin
            wake = ext_irq_line_six | ext_irq_low_group | pin_change_irq |
                   twi_addr_match_irq | mem_ready_irq | adc_done_irq | wdt_irq |
                   other_io_irq | usb_sync_irq | bus_voltage_transition_irq |
                   usb_resume_irq;
         end
         `MODE_ADC_QUIET: begin
            wake = (ext_irq_line_six & ext_irq_six_is_level) | ext_irq_low_group |
                   pin_change_irq | twi_addr_match_irq | mem_ready_irq |
                   adc_done_irq | wdt_irq | usb_sync_irq |
                   bus_voltage_transition_irq | usb_resume_irq;
         end
         default: begin
            wake = (ext_irq_line_six & ext_irq_six_is_level) | ext_irq_low_group |
                   pin_change_irq | twi_addr_match_irq | wdt_irq |
                   bus_voltage_transition_irq | usb_resume_irq;
         end
      endcase
   end

   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         ST_RUN: begin
            if (sleep_instr && sleep_arm_r) begin
               state_nxt = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (sys_reset_req || wake) begin
               state_nxt = ST_STARTUP;
               if (cur_mode_r == `MODE_POWER_DOWN) begin
                  cnt_nxt = startup_r;
               end else if (cur_mode_r == `MODE_STANDBY) begin
                  cnt_nxt = 16'd`STANDBY_WAKE_CYCLES - 16'd`INT_WAKE_HOLD_CYCLES;
               end else begin
                  cnt_nxt = 16'd1;
               end
            end
         end
         ST_STARTUP: begin
            if (cnt_r <= 16'd1) begin
               state_nxt = reset_wake_r ? ST_RUN : ST_HOLD;
               cnt_nxt = 16'd`INT_WAKE_HOLD_CYCLES;
            end else begin
               cnt_nxt = cnt_r - 16'd1;
            end
         end
         ST_HOLD: begin
            if (cnt_r <= 16'd1) begin
               state_nxt = ST_RUN;
            end else begin
               cnt_nxt = cnt_r - 16'd1;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_RUN;
         cnt_r <= 16'h0000;
         cur_mode_r <= `MODE_IDLE;
         reset_wake_r <= 1'b0;
         irq_wake_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         if (state_r == ST_RUN && sleep_instr && sleep_arm_r) begin
            cur_mode_r <= mode_nxt;
            reset_wake_r <= 1'b0;
            irq_wake_r <= 1'b0;
         end
         if (state_r == ST_SLEEP && (sys_reset_req || wake)) begin
            reset_wake_r <= sys_reset_req;
            irq_wake_r <= ~sys_reset_req;
         end
      end
   end

   // Gates change only at pclk edges, so each domain gets whole periods
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_clock_en <= 1'b1;
         flash_clock_en <= 1'b1;
         io_clock_en <= 1'b1;
         converter_clock_en <= 1'b1;
         usb_clock_en <= 1'b1;
         osc_en <= 1'b1;
         core_hold <= 1'b0;
         adc_auto_start <= 1'b0;
         resume_at_reset_vector <= 1'b0;
         wake_irq_pending <= 1'b0;
      end else begin
         core_hold <= (state_nxt != ST_RUN);
         core_clock_en <= (state_nxt != ST_SLEEP);
         flash_clock_en <= (state_nxt != ST_SLEEP);
         io_clock_en <= (state_nxt != ST_SLEEP) || mode_nxt == `MODE_IDLE;
         converter_clock_en <= (state_nxt != ST_SLEEP) ||
                               mode_nxt == `MODE_IDLE || mode_nxt == `MODE_ADC_QUIET;
         usb_clock_en <= converter_clock_en_src(state_nxt, mode_nxt);
         osc_en <= (state_nxt != ST_SLEEP) ||
                   mode_nxt != `MODE_POWER_DOWN;
         adc_auto_start <= (state_r == ST_RUN && sleep_instr && sleep_arm_r &&
                            adc_enabled &&
                            (sleep_mode_select_r == `MODE_IDLE ||
                             sleep_mode_select_r == `MODE_ADC_QUIET));
         resume_at_reset_vector <= (state_r != ST_RUN && state_nxt == ST_RUN &&
                                    reset_wake_r);
         wake_irq_pending <= (state_r != ST_RUN && state_nxt == ST_RUN && irq_wake_r);
      end
   end

   function converter_clock_en_src;
      input [2:0] st;
      input [2:0] m;
      begin
         converter_clock_en_src = (st != ST_SLEEP) || m == `MODE_IDLE ||
                                  m == `MODE_ADC_QUIET;
      end
   endfunction

   // APB registers, zero wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_mode_select_r <= CTRL_RST[`MODE_MSB:`MODE_LSB];
         sleep_arm_r <= CTRL_RST[`ARM_BIT];
         xtal_clock_r <= 1'b0;
         startup_r <= STARTUP_CYCLES;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (wr && pready) begin
            case (paddr)
               `SLEEP_CONTROL_REG_OFF: begin
                  sleep_mode_select_r <= pwdata[`MODE_MSB:`MODE_LSB];
                  sleep_arm_r <= pwdata[`ARM_BIT];
               end
               `SLEEP_CONFIG_REG_OFF: begin
                  xtal_clock_r <= pwdata[`CFG_XTAL_BIT];
                  startup_r <= (pwdata[31:16] == 16'h0000) ? 16'h0001 : pwdata[31:16];
               end
               `SLEEP_STATUS_REG_OFF: begin
               end
               default: begin
               end
            endcase
         end
         if (psel && !penable) begin
            pslverr <= !(paddr == `SLEEP_CONTROL_REG_OFF ||
                         paddr == `SLEEP_STATUS_REG_OFF ||
                         paddr == `SLEEP_CONFIG_REG_OFF);
            case (paddr)
               `SLEEP_CONTROL_REG_OFF: prdata <= {28'h0000000, sleep_mode_select_r,
                                                  sleep_arm_r};
               `SLEEP_STATUS_REG_OFF: prdata <= {23'h000000, reset_wake_r,
                                                 1'b0, cur_mode_r, 1'b0, state_r};
               `SLEEP_CONFIG_REG_OFF: prdata <= {startup_r, 15'h0000, xtal_clock_r};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

// ==== sleep_mode_controller_tb.sv ====
`timescale 1ns/1ps
module sleep_mode_controller_tb;
   reg pclk, presetn, psel, penable, pwrite, go, sys_reset_req, adc_enabled, slv;
   reg [11:0] paddr, src;
   reg [31:0] pwdata, q, rnd;
   wire [31:0] prdata;
   wire pready, pslverr, sleep_instr, core_hold, resume_at_reset_vector, wake_irq_pending;
   wire adc_auto_start, core_clock_en, flash_clock_en, io_clock_en;
   wire converter_clock_en, usb_clock_en, osc_en;
   int err_total = 0, n_tests = 0, cyc = 0, n, w;
   // Expected wake mask per mode, bit i is source i
   int mask [8] = '{12'hFFF, 12'hEFD, 12'hC9D, 12'hC9D, 0, 0, 12'hC9D, 12'hC9D};
   int modes [6] = '{0, 1, 2, 3, 6, 7};
   sleep_mode_controller #(.STARTUP_CYCLES(16'd4)) i_sleep_mode_controller (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_instr,
      .sys_reset_req, .core_hold, .resume_at_reset_vector, .wake_irq_pending,
      .ext_irq_line_six(src[0] | src[1]), .ext_irq_six_is_level(~src[1]),
      .ext_irq_low_group(src[2]), .pin_change_irq(src[3]), .twi_addr_match_irq(src[4]),
      .mem_ready_irq(src[5]), .adc_done_irq(src[6]), .wdt_irq(src[7]), .other_io_irq(src[8]),
      .usb_sync_irq(src[9]), .bus_voltage_transition_irq(src[10]), .usb_resume_irq(src[11]),
      .adc_enabled, .adc_auto_start, .core_clock_en, .flash_clock_en, .io_clock_en,
      .converter_clock_en, .usb_clock_en, .osc_en);
   core_model i_core_model (.pclk, .presetn, .go, .core_hold, .sleep_instr);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end
   task conclude;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (exp !== got) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_total++;
         $display("Error pready expected 1 seen %b", pready);
      end
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task sleep_go;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   task wait_run;
      for (w = 0; core_hold === 1'b1 && w < 40; w++) @(posedge pclk);
   endtask
   task sleep_case(input int m, input int i);
      adc_enabled <= 1'($urandom);
      apb(1'b1, 12'h000, m * 2 + 1);
      sleep_go();
      chk("asleep", 1, core_hold);
      chk("flash gated", 0, flash_clock_en);
      src <= 12'h001 << i;
      wait_run();
      chk("wake", (mask[m] >> i) & 1, !core_hold);
      chk("irq pulse", (mask[m] >> i) & 1, wake_irq_pending);
      // Watchdog wakes every mode, so the next case starts awake
      src <= 12'h080;
      wait_run();
      src <= 12'h000;
      apb(1'b1, 12'h000, m * 2);
   endtask
   initial begin
      {psel, penable, pwrite, go, sys_reset_req, adc_enabled, presetn} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      src = 12'h000;
      void'($urandom(32'h68A6C6B8));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h000, 0);
      chk("ctrl reset", 0, q);
      rnd = $urandom;
      apb(1'b1, 12'h000, rnd);
      apb(1'b0, 12'h000, 0);
      chk("ctrl bits", rnd & 32'hF, q);
      apb(1'b0, 12'h00C, 0);
      chk("unmapped", 1, slv);
      apb(1'b1, 12'h008, 32'h0004_0001);
      apb(1'b1, 12'h000, 32'h4);
      sleep_go();
      chk("unarmed", 0, core_hold);
      $display("register and arm test done");
      foreach (modes[k])
         for (int i = 0; i < 12; i++)
            sleep_case(modes[k], i);
      $display("wake table test done");
      apb(1'b1, 12'h000, 32'h5);
      sleep_go();
      sys_reset_req <= 1'b1;
      @(posedge pclk);
      sys_reset_req <= 1'b0;
      for (w = 0; resume_at_reset_vector !== 1'b1 && w < 100; w++) @(posedge pclk);
      chk("reset vector", 1, resume_at_reset_vector);
      $display("reset wake test done");
      conclude();
   end
endmodule
